// ### core/sdpi_map.svh
`ifndef SDPI_MAP_SVH
`define SDPI_MAP_SVH

// address decode of the SDRAM space
`define SDPI_REGION_HI     31
`define SDPI_REGION_LO     26
`define SDPI_REGION_CODE   6'h01
`define SDPI_ROW_HI        21
`define SDPI_ROW_LO        10
`define SDPI_COL_HI        9
`define SDPI_COL_LO        0
`define SDPI_ODD_BIT       0
`define SDPI_ROW_A10_BIT   10
`define SDPI_ADDR_W        12
`define SDPI_MODE_WORD     12'h030

// command codes as {row strobe, column strobe, write strobe}
`define SDPI_CMD_NOP       3'h7
`define SDPI_CMD_ACT       3'h3
`define SDPI_CMD_READ      3'h5
`define SDPI_CMD_WRITE     3'h4
`define SDPI_CMD_PRE       3'h2
`define SDPI_CMD_REF       3'h1
`define SDPI_CMD_MRS       3'h0

// timing, in ns, and cycle counts derived from the clock period
`define SDPI_CLK_NS        25
`define SDPI_T_RP_NS       20
`define SDPI_T_RCD_NS      20
`define SDPI_T_CAS_NS      75
`define SDPI_T_RFC_NS      70
`define SDPI_T_MRD_NS      50
`define SDPI_T_XSR_NS      80
`define SDPI_REFRESH_NS    15600
`define SDPI_WAIT_W        4
`define SDPI_CEIL(ns)      (((ns) + `SDPI_CLK_NS - 1) / `SDPI_CLK_NS)
`define SDPI_WAIT(ns)      4'(`SDPI_CEIL(ns) - 1)
`define SDPI_REFRESH_CYC   (`SDPI_REFRESH_NS / `SDPI_CLK_NS)
`define SDPI_REF_CNT_W     10

`endif

// ### core/sdpi_pin_interface.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdpi_map.svh"
// Summary of operation
// - space select low on every SDRAM command whose address hits the region
// - only the bus owner drives space select; others leave it floating
// - row strobe low marks valid row address in read or write
// - column strobe low marks valid column address in read or write
// - with column strobe low, write strobe low for write, high for read
// - a high word mask disables that word's data buffers
// - masks only meaningful with column strobe; both inactive on reads
// - on 64-bit writes to an odd word, assert the low mask
// - high mask on single writes to even words, or always in 32-bit mode
// - address bit ten on its own pin so refresh leaves the bus free
// - clock enable enters and leaves self-refresh and suspend
// - master keeps clock enable weakly high, low in self-refresh; slaves none; the code drives neither keeper in suspend
// - before host takes the bus, enter self-refresh and float all lines
module sdpi_pin_interface
(
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // core request
    input  wire logic                     reqValid,
    input  wire logic                     reqWrite,
    input  wire logic                     reqSingle,
    input  wire logic [31:0]              reqAddr,
    output logic                          reqReady,
    // configuration and power control
    input  wire logic                     bus32Mode,
    input  wire logic                     selfRefreshReq,
    input  wire logic                     suspendReq,
    input  wire logic                     busOwner,
    input  wire logic                     singleProcessor,
    // pins sampled from outside
    input  wire logic [2:0]               multiprocessorIndex,
    input  wire logic                     hostBusRequestN,
    // SDRAM control pins
    output logic                          sdramSpaceSelectN,
    output logic                          rowStrobeN,
    output logic                          colStrobeN,
    output logic                          sdramWriteStrobeN,
    output logic                          lowWordMask,
    output logic                          highWordMask,
    output logic                          refreshAddrBitTen,
    output logic                          sdramClockEnable,
    output logic [`SDPI_ADDR_W-1:0]       sdramAddr,
    // output enables and keepers
    output logic                          ctrlOe,
    output logic                          addrOe,
    output logic                          ckeKeepHigh,
    output logic                          ckeKeepLow,
    // status
    output logic                          busReleased,
    output logic                          selfRefreshActive,
    output sdpi_pkg::sdpi_state_t         fsmState
);
    import sdpi_pkg::*;
    // a literal cannot be bit-selected, so the mode word gets a name
    localparam logic [`SDPI_ADDR_W-1:0] MODE_WORD = `SDPI_MODE_WORD;

    sdpi_state_t                stateQ;
    logic [2:0]                 cmdQ;
    logic [`SDPI_WAIT_W-1:0]    waitQ;
    logic [`SDPI_ADDR_W-1:0]    addrQ;
    logic                       a10Q;
    logic                       lowMaskQ;
    logic                       highMaskQ;
    logic                       ckeQ;
    logic                       addrOeQ;
    logic                       ctrlOeQ;
    logic                       releasedQ;
    logic                       refreshPendingQ;
    logic                       keepHighQ;
    logic                       keepLowQ;
    logic [3:0]                 syncAQ;
    logic [3:0]                 syncBQ;
    logic                       hostReq;
    logic                       primary;
    logic                       refreshTick;
    logic                       refreshIssue;
    logic                       regionHit;
    logic                       idleFree;
    logic                       reqWriteQ;
    logic                       singleQ;
    logic                       oddQ;
    logic [`SDPI_COL_HI:`SDPI_COL_LO] colQ;

    // pin synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            syncAQ <= 4'hF;
            syncBQ <= 4'hF;
        end
        else
        begin
            syncAQ <= {hostBusRequestN, multiprocessorIndex};
            syncBQ <= syncAQ;
        end
    end

    assign hostReq   = busOwner && !syncBQ[3];
    assign primary   = busOwner || (singleProcessor && syncBQ[2:0] == 3'h0);
    assign regionHit = reqAddr[`SDPI_REGION_HI:`SDPI_REGION_LO]
                       == `SDPI_REGION_CODE;
    assign idleFree  = stateQ == ST_IDLE && waitQ == '0 && busOwner
                       && !refreshPendingQ && !hostReq && !selfRefreshReq;
    assign reqReady  = idleFree && regionHit;

    sdpi_tick_divider
    #(
        .PERIOD (`SDPI_REFRESH_CYC)
    )
    u_refresh_tick
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .countEn (!selfRefreshActive),
        .tick    (refreshTick)
    );

    assign refreshIssue = waitQ == '0 && stateQ == ST_IDLE && busOwner
                          && refreshPendingQ;

    // a tick in the issuing cycle stays pending
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            refreshPendingQ <= 1'b0;
        else if (refreshTick)
            refreshPendingQ <= 1'b1;
        else if (refreshIssue)
            refreshPendingQ <= 1'b0;
    end

    // command sequencer; every command is one cycle, NOP otherwise
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            stateQ    <= ST_INIT_PRE;
            cmdQ      <= `SDPI_CMD_NOP;
            waitQ     <= '0;
            addrQ     <= '0;
            a10Q      <= 1'b0;
            lowMaskQ  <= 1'b0;
            highMaskQ <= 1'b0;
            ckeQ      <= 1'b1;
            addrOeQ   <= 1'b0;
            releasedQ <= 1'b0;
        end
        else
        begin
            cmdQ      <= `SDPI_CMD_NOP;
            addrOeQ   <= 1'b0;
            lowMaskQ  <= 1'b0;
            highMaskQ <= 1'b0;
            if (waitQ != '0)
                waitQ <= waitQ - `SDPI_WAIT_W'(1);
            else
            begin
                unique case (stateQ)
                    ST_INIT_PRE:
                    begin
                        cmdQ   <= `SDPI_CMD_PRE;
                        a10Q   <= 1'b1;
                        waitQ  <= `SDPI_WAIT(`SDPI_T_RP_NS);
                        stateQ <= ST_INIT_REF1;
                    end
                    ST_INIT_REF1, ST_INIT_REF2:
                    begin
                        cmdQ   <= `SDPI_CMD_REF;
                        waitQ  <= `SDPI_WAIT(`SDPI_T_RFC_NS);
                        stateQ <= (stateQ == ST_INIT_REF1) ? ST_INIT_REF2
                                                           : ST_INIT_MRS;
                    end
                    ST_INIT_MRS:
                    begin
                        cmdQ    <= `SDPI_CMD_MRS;
                        addrQ   <= MODE_WORD;
                        a10Q    <= MODE_WORD[`SDPI_ROW_A10_BIT];
                        addrOeQ <= 1'b1;
                        waitQ   <= `SDPI_WAIT(`SDPI_T_MRD_NS);
                        stateQ  <= ST_IDLE;
                    end
                    ST_IDLE:
                    begin
                        if (!busOwner)
                            stateQ <= ST_IDLE;
                        else if (refreshPendingQ)
                        begin
                            // refresh leaves the shared address bus idle
                            cmdQ  <= `SDPI_CMD_REF;
                            a10Q  <= 1'b0;
                            waitQ <= `SDPI_WAIT(`SDPI_T_RFC_NS);
                        end
                        else if (hostReq || selfRefreshReq)
                            stateQ <= ST_SR_PRE;
                        else if (reqValid && regionHit)
                        begin
                            cmdQ    <= `SDPI_CMD_ACT;
                            addrQ   <= reqAddr[`SDPI_ROW_HI:`SDPI_ROW_LO];
                            a10Q    <= reqAddr[`SDPI_ROW_LO +
                                               `SDPI_ROW_A10_BIT];
                            addrOeQ <= 1'b1;
                            waitQ   <= `SDPI_WAIT(`SDPI_T_RCD_NS);
                            stateQ  <= ST_ACT;
                        end
                        else if (suspendReq)
                        begin
                            ckeQ   <= 1'b0;
                            stateQ <= ST_SUSPEND;
                        end
                    end
                    ST_ACT:
                    begin
                        cmdQ    <= reqWriteQ ? `SDPI_CMD_WRITE
                                             : `SDPI_CMD_READ;
                        addrQ   <= `SDPI_ADDR_W'(colQ);
                        a10Q    <= 1'b0;
                        addrOeQ <= 1'b1;
                        // masks only on writes, never on reads
                        lowMaskQ  <= reqWriteQ && !bus32Mode
                                     && oddQ;
                        highMaskQ <= reqWriteQ && (bus32Mode
                                     || (singleQ && !oddQ));
                        waitQ   <= `SDPI_WAIT(`SDPI_T_CAS_NS);
                        stateQ  <= ST_CAS;
                    end
                    ST_CAS, ST_SR_PRE:
                    begin
                        // closed-page policy: simple, costs an activate
                        cmdQ   <= `SDPI_CMD_PRE;
                        a10Q   <= 1'b1;
                        waitQ  <= `SDPI_WAIT(`SDPI_T_RP_NS);
                        stateQ <= (stateQ == ST_CAS) ? ST_PRE : ST_SR_ENTER;
                    end
                    ST_PRE:
                        stateQ <= ST_IDLE;
                    ST_SR_ENTER:
                    begin
                        cmdQ   <= `SDPI_CMD_REF;
                        ckeQ   <= 1'b0;
                        stateQ <= ST_SELF;
                    end
                    ST_SELF:
                    begin
                        releasedQ <= hostReq;
                        if (!hostReq && !selfRefreshReq && busOwner)
                        begin
                            ckeQ      <= 1'b1;
                            releasedQ <= 1'b0;
                            waitQ     <= `SDPI_WAIT(`SDPI_T_XSR_NS);
                            stateQ    <= ST_IDLE;
                        end
                    end
                    ST_SUSPEND:
                    begin
                        if (!suspendReq || refreshPendingQ || hostReq)
                        begin
                            ckeQ   <= 1'b1;
                            stateQ <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // request capture, taken on the accepting edge
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            reqWriteQ <= 1'b0;
            singleQ   <= 1'b0;
            oddQ      <= 1'b0;
            colQ      <= '0;
        end
        else if (reqValid && reqReady)
        begin
            reqWriteQ <= reqWrite;
            singleQ   <= reqSingle;
            oddQ      <= reqAddr[`SDPI_ODD_BIT];
            colQ      <= reqAddr[`SDPI_COL_HI:`SDPI_COL_LO];
        end
    end

    // drive roles and clock enable keepers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrlOeQ   <= 1'b0;
            keepHighQ <= 1'b0;
            keepLowQ  <= 1'b0;
        end
        else
        begin
            ctrlOeQ   <= busOwner && !releasedQ;
            keepHighQ <= primary && ckeQ;
            keepLowQ  <= primary && !ckeQ && stateQ == ST_SELF;
        end
    end

    assign rowStrobeN        = cmdQ[2];
    assign colStrobeN        = cmdQ[1];
    assign sdramWriteStrobeN = cmdQ[0];
    assign sdramSpaceSelectN = cmdQ == `SDPI_CMD_NOP;
    assign lowWordMask       = lowMaskQ;
    assign highWordMask      = highMaskQ;
    assign refreshAddrBitTen = a10Q;
    assign sdramClockEnable  = ckeQ;
    assign sdramAddr         = addrQ;
    assign ctrlOe            = ctrlOeQ;
    assign addrOe            = addrOeQ && ctrlOeQ;
    assign ckeKeepHigh       = keepHighQ;
    assign ckeKeepLow        = keepLowQ;
    assign busReleased       = releasedQ;
    assign selfRefreshActive = stateQ == ST_SELF;
    assign fsmState          = stateQ;

    // checks
    AST_SELECT_ON_CMD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!rowStrobeN || !colStrobeN) |-> !sdramSpaceSelectN)
        else $error("select not asserted on a command");
    AST_OWNER_DRIVES: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctrlOe |-> $past(busOwner))
        else $error("control driven without bus ownership");
    AST_ACT_TO_CAS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmdQ == `SDPI_CMD_ACT) |-> ##[1:4] (rowStrobeN && !colStrobeN))
        else $error("activate not followed by column command");
    AST_WRITE_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rowStrobeN && !colStrobeN) |-> (sdramWriteStrobeN == !reqWriteQ))
        else $error("write strobe disagrees with direction");
    AST_MASK_NEEDS_CAS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (lowWordMask || highWordMask) |-> (!colStrobeN && !sdramWriteStrobeN))
        else $error("mask outside a write column cycle");
    AST_LOW_MASK_ODD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmdQ == `SDPI_CMD_WRITE && !$past(bus32Mode))
        |-> (lowWordMask == oddQ))
        else $error("low mask wrong for word parity");
    AST_HIGH_MASK_32: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmdQ == `SDPI_CMD_WRITE && $past(bus32Mode)) |-> highWordMask)
        else $error("high mask missing in 32-bit mode");
    AST_REFRESH_FREE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cmdQ == `SDPI_CMD_REF) |-> !addrOe)
        else $error("address bus driven during refresh");
    AST_SELF_CKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(selfRefreshActive) |-> !sdramClockEnable [*2])
        else $error("clock enable high in self-refresh");
    AST_SLAVE_NO_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !primary |=> !(ckeKeepHigh || ckeKeepLow))
        else $error("keeper active on a slave");
    AST_RELEASE_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busReleased |-> (selfRefreshActive && !addrOe) ##1 !ctrlOe)
        else $error("lines driven after release");

    COV_WRITE: cover property (@(posedge sys_clk) cmdQ == `SDPI_CMD_WRITE);
    COV_READ: cover property (@(posedge sys_clk) cmdQ == `SDPI_CMD_READ);
    COV_RELEASE: cover property (@(posedge sys_clk) $rose(busReleased));
    COV_SUSPEND: cover property (@(posedge sys_clk) stateQ == ST_SUSPEND);

endmodule // sdpi_pin_interface

`default_nettype wire

// ### core/sdpi_pkg.sv
`include "sdpi_map.svh"

package sdpi_pkg;

    typedef enum logic [3:0] {
        ST_INIT_PRE,
        ST_INIT_REF1,
        ST_INIT_REF2,
        ST_INIT_MRS,
        ST_IDLE,
        ST_ACT,
        ST_CAS,
        ST_PRE,
        ST_SR_PRE,
        ST_SR_ENTER,
        ST_SELF,
        ST_SUSPEND
    } sdpi_state_t;

endpackage

// ### core/sdpi_tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdpi_map.svh"

module sdpi_tick_divider
#(
    parameter int PERIOD = `SDPI_REFRESH_CYC
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // control
    input  wire logic countEn,
    output logic      tick
);
    logic [`SDPI_REF_CNT_W-1:0] countQ;

    // counter clears while disabled so the interval restarts cleanly
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            countQ <= '0;
        else if (!countEn)
            countQ <= '0;
        else if (countQ == `SDPI_REF_CNT_W'(PERIOD - 1))
            countQ <= '0;
        else
            countQ <= countQ + `SDPI_REF_CNT_W'(1);
    end

    assign tick = countEn && (countQ == `SDPI_REF_CNT_W'(PERIOD - 1));

endmodule // sdpi_tick_divider

`default_nettype wire

// ### tb/sdpi_sdram_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdpi_map.svh"

module sdpi_sdram_model
(
    // clock
    input  wire logic        sys_clk,
    // command pins as the memory sees them
    input  wire logic        selN,
    input  wire logic        rasN,
    input  wire logic        casN,
    input  wire logic        weN,
    input  wire logic        cke,
    input  wire logic        oe,
    input  wire logic [11:0] addr,
    // observations for the bench
    output var  int          refCount,
    output var  logic        inSelfRefresh,
    output var  logic [11:0] modeWord
);
    logic [2:0] cmd;

    assign cmd = {rasN, casN, weN};

    initial
    begin
        refCount = 0;
        inSelfRefresh = 1'b0;
        modeWord = 12'h000;
    end

    // floating pins (oe low) are ignored, as a real part would see noise
    always @(posedge sys_clk)
    begin
        if (oe && !selN && cmd == `SDPI_CMD_REF)
        begin
            if (cke)
                refCount <= refCount + 1;
            else
                inSelfRefresh <= 1'b1;
        end
        if (oe && !selN && cmd == `SDPI_CMD_MRS)
            modeWord <= addr;
        if (inSelfRefresh && oe && cke)
            inSelfRefresh <= 1'b0;
    end
endmodule // sdpi_sdram_model
`default_nettype wire

// ### tb/tb_sdpi_pin_interface.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdpi_map.svh"

module tb_sdpi_pin_interface;
    import sdpi_pkg::*;
    logic        sys_clk = 1'b0, rst_n = 1'b0;
    logic        reqValid = 1'b0, reqWrite = 1'b0, reqSingle = 1'b0;
    logic [31:0] reqAddr = 32'h0;
    logic        bus32Mode = 1'b0, selfRefreshReq = 1'b0, suspendReq = 1'b0;
    logic        busOwner = 1'b1, singleProcessor = 1'b0, hostBusRequestN = 1'b1;
    logic [2:0]  multiprocessorIndex = 3'h1;
    logic        reqReady, selN, rasN, casN, weN, lowMask, highMask;
    logic        a10, cke, ctrlOe, addrOe, keepHi, keepLo, released, srAct;
    logic [11:0] sdramAddr, modeWord;
    logic [2:0]  cmd;
    logic        inSelfRefresh;
    sdpi_state_t fsmState;
    int          numErrors = 0, cmpCount = 0, cycles = 0, refCount, n;

    assign cmd = {rasN, casN, weN};
    always #12.5 sys_clk = ~sys_clk;

    sdpi_pin_interface u_sdpi_pin_interface (.sys_clk(sys_clk), .rst_n(rst_n),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqSingle(reqSingle),
        .reqAddr(reqAddr), .reqReady(reqReady), .bus32Mode(bus32Mode),
        .selfRefreshReq(selfRefreshReq), .suspendReq(suspendReq),
        .busOwner(busOwner), .singleProcessor(singleProcessor),
        .multiprocessorIndex(multiprocessorIndex),
        .hostBusRequestN(hostBusRequestN), .sdramSpaceSelectN(selN),
        .rowStrobeN(rasN), .colStrobeN(casN), .sdramWriteStrobeN(weN),
        .lowWordMask(lowMask), .highWordMask(highMask),
        .refreshAddrBitTen(a10), .sdramClockEnable(cke),
        .sdramAddr(sdramAddr), .ctrlOe(ctrlOe), .addrOe(addrOe),
        .ckeKeepHigh(keepHi), .ckeKeepLow(keepLo), .busReleased(released),
        .selfRefreshActive(srAct), .fsmState(fsmState));

    sdpi_sdram_model u_sdpi_sdram_model (.sys_clk(sys_clk), .selN(selN),
        .rasN(rasN), .casN(casN), .weN(weN), .cke(cke), .oe(ctrlOe),
        .addr(sdramAddr), .refCount(refCount), .inSelfRefresh(inSelfRefresh),
        .modeWord(modeWord));

    function automatic bit ok(input logic c);
        cmpCount++;
        return c === 1'b1;
    endfunction

    task automatic err(input string m);
        numErrors++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task automatic complete_run();
        $display("errors %0d comparisons %0d", numErrors, cmpCount);
        if (numErrors == 0 && cmpCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one nanosecond after the edge, so registered pins have settled
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    // closed-page access: take, ACT, column command, PRE
    task automatic access(input logic wr, sgl, b32, input logic [31:0] a);
        logic expLo, expHi;
        expLo = wr && !b32 && a[0];
        expHi = wr && (b32 || (sgl && !a[0]));
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqSingle <= sgl;
        reqAddr <= a;
        bus32Mode <= b32;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (reqReady !== 1'b1 && n < 2000);
        if (!ok(n < 2000)) err("request never taken");
        @(posedge sys_clk);
        reqValid <= 1'b0;
        #1;
        if (!ok(cmd === `SDPI_CMD_ACT)) err("no activate");
        if (!ok(selN === 1'b0)) err("select not low on activate");
        if (!ok(rasN === 1'b0 && addrOe === 1'b1)) err("row strobe");
        if (!ok(sdramAddr === a[21:10])) err("row address wrong");
        tick();
        if (!ok(cmd === (wr ? `SDPI_CMD_WRITE : `SDPI_CMD_READ)))
            err("column command wrong");
        if (!ok(weN === !wr)) err("write strobe wrong");
        if (!ok(sdramAddr[9:0] === a[9:0])) err("column addr wrong");
        if (!ok(lowMask === expLo)) err("low mask wrong");
        if (!ok(highMask === expHi)) err("high mask wrong");
        n = 0;
        do
        begin
            tick();
            n++;
            if (!ok(casN === 1'b1 || (lowMask === 1'b0 && highMask === 1'b0)))
                err("stray mask");
        end
        while (cmd !== `SDPI_CMD_PRE && n < 8);
        if (!ok(cmd === `SDPI_CMD_PRE && a10 === 1'b1)) err("no precharge");
    endtask

    // two idle refreshes, spaced by the refresh interval
    task automatic refreshGap();
        int r0;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            r0 = refCount;
            do
            begin
                tick();
                n++;
            end
            while (!(cmd === `SDPI_CMD_REF && selN === 1'b0) && n < 700);
            if (!ok(n < 700)) err("no refresh");
            if (!ok(addrOe === 1'b0 && cke === 1'b1)) err("refresh pins");
            tick();
            if (!ok(refCount == r0 + 1)) err("memory saw no refresh");
            if (k == 1 && !ok(n >= 622 && n <= 626)) err("refresh gap");
        end
    endtask

    task automatic hostHandover();
        @(posedge sys_clk);
        hostBusRequestN <= 1'b0;
        n = 0;
        do
        begin
            tick();
            n++;
        end
        while (ctrlOe !== 1'b0 && n < 30);
        if (!ok(released === 1'b1 && srAct === 1'b1)) err("bus not given");
        if (!ok(inSelfRefresh === 1'b1 && cke === 1'b0)) err("no self-ref");
        if (!ok(keepLo === 1'b1 && keepHi === 1'b0)) err("keeper low");
        if (!ok(addrOe === 1'b0)) err("address not floated");
        if (!ok(fsmState === ST_SELF)) err("state not self-refresh");
        @(posedge sys_clk);
        hostBusRequestN <= 1'b1;
        repeat (12) tick();
        if (!ok(cke === 1'b1 && released === 1'b0)) err("no exit");
        if (!ok(ctrlOe === 1'b1 && keepHi === 1'b1)) err("keeper high");
    endtask

    // requested self-refresh without a host keeps the bus driven
    task automatic selfRefreshCycle();
        @(posedge sys_clk);
        selfRefreshReq <= 1'b1;
        repeat (10) tick();
        if (!ok(srAct === 1'b1 && cke === 1'b0)) err("no self-refresh");
        if (!ok(keepLo === 1'b1 && keepHi === 1'b0)) err("keeper");
        if (!ok(released === 1'b0 && ctrlOe === 1'b1)) err("released");
        @(posedge sys_clk);
        selfRefreshReq <= 1'b0;
        repeat (8) tick();
        if (!ok(srAct === 1'b0 && cke === 1'b1)) err("self-ref kept");
    endtask

    // a request that must stay refused for many cycles
    task automatic refused(input logic own, input logic [31:0] a);
        @(posedge sys_clk);
        busOwner <= own;
        reqAddr <= a;
        reqValid <= 1'b1;
        repeat (20)
        begin
            @(negedge sys_clk);
            if (!ok(reqReady === 1'b0)) err("request accepted");
        end
        if (!ok(own || (keepHi === 1'b0 && keepLo === 1'b0)))
            err("slave drives keeper");
        @(posedge sys_clk);
        reqValid <= 1'b0;
        busOwner <= 1'b1;
    endtask

    task automatic suspendCycle();
        @(posedge sys_clk);
        suspendReq <= 1'b1;
        repeat (10) tick();
        if (!ok(cke === 1'b0)) err("suspend not entered");
        @(posedge sys_clk);
        suspendReq <= 1'b0;
        repeat (5) tick();
        if (!ok(cke === 1'b1)) err("suspend not left");
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err("timeout");
            complete_run();
        end
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        access(1'b1, 1'b0, 1'b0, 32'h0400_0C01);
        if (!ok(modeWord === `SDPI_MODE_WORD)) err("mode word");
        access(1'b1, 1'b1, 1'b0, 32'h0420_0402);
        access(1'b1, 1'b0, 1'b0, 32'h0400_0002);
        access(1'b1, 1'b0, 1'b1, 32'h0410_03FF);
        access(1'b0, 1'b1, 1'b0, 32'h043F_FC01);
        access(1'b0, 1'b0, 1'b1, 32'h0400_0000);
        refused(1'b1, 32'h0800_0000);
        refused(1'b0, 32'h0400_0010);
        refreshGap();
        selfRefreshCycle();
        hostHandover();
        suspendCycle();
        access(1'b1, 1'b0, 1'b0, 32'h0400_0001);
        complete_run();
    end
endmodule // tb_sdpi_pin_interface
`default_nettype wire
